// >>> psd_core.sv
// digital core of the channel synthesizer: dividers, phase
// detector, lock detector and the register file on APB.
// assumes rf_in, osc_input and the pins are asynchronous to clk
// and that rf and oscillator edges are slower than clk / 2.
// Summary of operation
// - prescaler output clocks main counter, rf edges clock swallow counter
// - 18-bit word: low 5 swallow, high 13 main
// - writing the lowest ratio register arms transfer
// - transfer happens on the divider output pulse
// - ratios 2048 to 262143 accepted
// - ratio below 2048 divides by value plus 2048
// - lowest-register-only write keeps upper bits
// - sixteen reference ratios from four-bit field
// - codes 0..15 map to 128 through 1920
// - dual flip-flop detector, no dead zone
// - up or down drives pump, else high impedance
// - bit 5 selects 1 mA or 0.5 mA
// - phase invert swaps up and down
// - faster variable asserts down unless inverted
// - unlock pulls vco_switch_a low
// - unlock readable in status register
// - error above 200 ns flags unlock at once
// - release after 6 clean reference cycles
// - four 8-bit control registers
// - power-down idles ratio and reference dividers, keeps registers
// - low hardware power-down pin forces power-down
// - output at one eighth of oscillator
// - address: 110001, inverted select, direction
module psd_core
    import psd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rf_in,
    input wire logic osc_input,
    input wire logic hw_powerdown_n,
    input wire logic addr_select_in,
    output psd_pump_t pump,
    output logic vco_switch_a_o,
    output logic vco_switch_a_oe,
    output logic vco_switch_b,
    output logic xtal_div8_out
);
    // input synchronisers: rf, osc, power-down, address select
    logic [3:0] s1_q, s2_q, s3_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 4'h4;
            s2_q <= 4'h4;
            s3_q <= 4'h4;
        end else begin
            s1_q <= {addr_select_in, hw_powerdown_n, osc_input, rf_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    wire rf_rise = s2_q[0] & ~s3_q[0];
    wire osc_rise = s2_q[1] & ~s3_q[1];

    // control registers
    logic [7:0] reg_a_q, reg_b_q, reg_c_q, reg_d_q;
    logic pready_q, pslverr_q, load_pend_q;
    logic [31:0] prdata_q;
    psd_lock_t lock_q;
    wire unlocked = (lock_q == PSD_UNLOCKED);
    // pin or register bit; control part stays alive either way
    wire pd = ~s2_q[2] | reg_a_q[A_PD];

    // apb decode
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_q;
    wire wr = acc & pwrite;
    wire hit_a = (paddr == OFF_A);
    wire hit_b = (paddr == OFF_B);
    wire hit_c = (paddr == OFF_C);
    wire hit_d = (paddr == OFF_D);
    wire hit_s = (paddr == OFF_STAT);
    wire hit_sa = (paddr == OFF_SADDR);
    wire mapped = hit_a | hit_b | hit_c | hit_d | hit_s | hit_sa;
    wire wr_d = wr & hit_d;

    // read mux
    logic [7:0] rbyte;
    logic [7:0] stat_byte;
    always_comb begin
        stat_byte = 8'h00;
        stat_byte[STAT_UNLOCK] = unlocked;
        if (hit_a) begin
            rbyte = reg_a_q;
        end else if (hit_b) begin
            rbyte = reg_b_q;
        end else if (hit_c) begin
            rbyte = reg_c_q;
        end else if (hit_d) begin
            rbyte = reg_d_q;
        end else if (hit_s) begin
            rbyte = stat_byte;
        end else if (hit_sa) begin
            rbyte = {SADDR_FIXED, ~s2_q[3], 1'b0};
        end else begin
            rbyte = 8'h00;
        end
    end

    // answer one cycle after setup: no wait states
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup) begin
                prdata_q <= {24'h0, rbyte};
            end
        end
    end

    // register writes; kept through power-down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_a_q <= RST_A;
            reg_b_q <= RST_B;
            reg_c_q <= RST_C;
            reg_d_q <= RST_D;
        end else begin
            if (wr & hit_a) reg_a_q <= pwdata[7:0];
            if (wr & hit_b) reg_b_q <= pwdata[7:0];
            if (wr & hit_c) reg_c_q <= pwdata[7:0];
            if (wr_d) reg_d_q <= pwdata[7:0];
        end
    end

    // buffered division word, floor applied
    wire [17:0] buf_word = {reg_b_q[1:0], reg_c_q, reg_d_q};
    wire [17:0] new_word = psd_eff_ratio(buf_word);

    // main divider state
    logic [12:0] act_n_q, main_q;
    logic [4:0] act_r_q, sw_q, pre_q;
    logic swp_q, var_pulse_q;
    // prescaler divides by 32 in the main phase; the swallow
    // phase passes single rf edges, giving 32 * n + r in total
    wire pre_wrap = rf_rise & ~swp_q & (pre_q == PRE_TOP);
    wire main_end = pre_wrap & (main_q == 13'h0001);
    wire sw_end = swp_q & rf_rise & (sw_q == 5'h01);
    wire fire = ~pd & ((main_end & (act_r_q == 5'h00)) | sw_end);
    // new word only enters at the output pulse
    wire take = fire & load_pend_q;
    wire [12:0] nxt_n = take ? new_word[17:5] : act_n_q;
    wire [4:0] nxt_r = take ? new_word[4:0] : act_r_q;

    // arming flag: a write in the take cycle re-arms
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_pend_q <= 1'b0;
        end else begin
            load_pend_q <= wr_d | (load_pend_q & ~take);
        end
    end

    // active ratio and counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_n_q <= 13'h0800;
            act_r_q <= 5'h00;
            main_q <= 13'h0800;
            sw_q <= 5'h00;
            pre_q <= 5'h00;
            swp_q <= 1'b0;
        end else if (pd) begin
            // idle: hold the chain at its start
            main_q <= act_n_q;
            sw_q <= act_r_q;
            pre_q <= 5'h00;
            swp_q <= 1'b0;
        end else if (fire) begin
            act_n_q <= nxt_n;
            act_r_q <= nxt_r;
            main_q <= nxt_n;
            sw_q <= nxt_r;
            pre_q <= 5'h00;
            swp_q <= 1'b0;
        end else if (main_end) begin
            swp_q <= 1'b1;
            pre_q <= 5'h00;
        end else if (sw_end | (swp_q & rf_rise)) begin
            sw_q <= sw_q - 5'h01;
        end else if (rf_rise) begin
            pre_q <= pre_q + 5'h01;
            if (pre_wrap) main_q <= main_q - 13'h0001;
        end
    end

    // counter chain checks: main moves only on a prescaler wrap
    a_main_step: assert property (@(posedge clk) disable iff (!rst_n)
        !pd && !fire && !pre_wrap |=> $stable(main_q))
        else $error("main counter moved off prescaler wrap");
    a_pre_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        pre_wrap |=> pre_q == 5'h00)
        else $error("prescaler did not restart after wrap");

    // reference divider and crystal divide-by-8
    logic [10:0] ref_q;
    logic [1:0] x8_q;
    logic ref_pulse_q, x8_out_q;
    wire [10:0] ref_load = psd_ref_ratio(reg_a_q[A_REF+:4]);
    wire ref_end = osc_rise & (ref_q <= 11'h001);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_q <= 11'h080;
            ref_pulse_q <= 1'b0;
            var_pulse_q <= 1'b0;
        end else begin
            var_pulse_q <= fire;
            ref_pulse_q <= ref_end & ~pd;
            if (pd | ref_end) ref_q <= ref_load;
            else if (osc_rise) ref_q <= ref_q - 11'h001;
        end
    end

    // keeps running in power-down; control part clock out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            x8_q <= 2'h0;
            x8_out_q <= 1'b0;
        end else if (osc_rise) begin
            x8_q <= x8_q + 2'h1;
            if (x8_q == 2'h3) x8_out_q <= ~x8_out_q;
        end
    end

    // phase/frequency detector: both set clears both next cycle,
    // the one-cycle overlap removes the dead zone
    logic r_ff_q, v_ff_q;
    wire both = r_ff_q & v_ff_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff_q <= 1'b0;
            v_ff_q <= 1'b0;
        end else begin
            r_ff_q <= ~pd & ~both & (r_ff_q | ref_pulse_q);
            v_ff_q <= ~pd & ~both & (v_ff_q | var_pulse_q);
        end
    end
    wire phase_invert = reg_b_q[B_PHI];
    wire pfd_up = phase_invert ? v_ff_q : r_ff_q;
    wire pfd_dn = phase_invert ? r_ff_q : v_ff_q;

    // charge pump command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pump <= '{up: 1'b0, dn: 1'b0, hiz: 1'b1, hi_cur: 1'b0};
        end else begin
            pump.up <= pfd_up;
            pump.dn <= pfd_dn;
            pump.hiz <= ~(pfd_up | pfd_dn);
            pump.hi_cur <= reg_a_q[A_ICP];
        end
    end

    // lock detector: time the error pulse, count clean refs
    logic [3:0] err_q;
    logic [2:0] good_q;
    logic seen_q;
    wire err_on = r_ff_q | v_ff_q;
    wire big = err_on & (err_q >= ERR_CYC);
    wire clean_ref = ref_pulse_q & ~seen_q & ~big;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 4'h0;
            seen_q <= 1'b0;
        end else begin
            if (!err_on) err_q <= 4'h0;
            else if (err_q < ERR_CYC) err_q <= err_q + 4'h1;
            seen_q <= big | (seen_q & ~ref_pulse_q);
        end
    end

    // lock state machine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= PSD_UNLOCKED;
            good_q <= 3'h0;
        end else begin
            case (lock_q)
                PSD_LOCKED: begin
                    good_q <= 3'h0;
                    if (big) lock_q <= PSD_UNLOCKED;
                end
                PSD_UNLOCKED: begin
                    if (big | (ref_pulse_q & ~clean_ref)) begin
                        good_q <= 3'h0;
                    end else if (clean_ref) begin
                        good_q <= good_q + 3'h1;
                        if (good_q == RELOCK_REFS - 3'h1) begin
                            lock_q <= PSD_LOCKED;
                        end
                    end
                end
                default: lock_q <= PSD_UNLOCKED;
            endcase
        end
    end

    // switch pins: vco_switch_a open-collector, vco_switch_b driven high and low
    logic va_oe_q, vb_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            va_oe_q <= 1'b1;
            vb_q <= 1'b0;
        end else begin
            va_oe_q <= unlocked | ~reg_b_q[B_VCO_SWITCH_A];
            vb_q <= reg_b_q[B_VCO_SWITCH_B];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign vco_switch_a_o = 1'b0;
    assign vco_switch_a_oe = va_oe_q;
    assign vco_switch_b = vb_q;
    assign xtal_div8_out = x8_out_q;

    // checks
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr_d;
        wr_d;
    endsequence

    a_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
        s_setup |=> pready) else $error("no answer after setup");
    a_unlock_fast: assert property (@(posedge clk)
        disable iff (!rst_n)
        big |=> unlocked ##1 !vco_switch_a_o && vco_switch_a_oe)
        else $error("unlock not flagged at once");
    a_relock_count: assert property (@(posedge clk)
        disable iff (!rst_n)
        $fell(unlocked) |-> $past(good_q) == RELOCK_REFS - 3'h1)
        else $error("relock after wrong ref count");
    a_pump_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        pump.hiz == !(pump.up || pump.dn)) else $error("pump hiz wrong");
    a_invert_swap: assert property (@(posedge clk)
        disable iff (!rst_n)
        (v_ff_q && !r_ff_q && $stable(phase_invert)) |=> (phase_invert ? pump.up : pump.dn))
        else $error("detector polarity wrong");
    a_ratio_floor: assert property (@(posedge clk) disable iff (!rst_n)
        take |=> {act_n_q, act_r_q} >= RATIO_MIN)
        else $error("ratio below floor loaded");
    a_load_sync: assert property (@(posedge clk) disable iff (!rst_n)
        !fire |=> $stable(act_n_q) && $stable(act_r_q))
        else $error("ratio changed off output pulse");
    a_partial_upd: assert property (@(posedge clk)
        disable iff (!rst_n)
        s_wr_d |=> $stable(reg_b_q) && $stable(reg_c_q) && load_pend_q)
        else $error("partial write disturbed upper bits");
    a_pd_idle: assert property (@(posedge clk) disable iff (!rst_n)
        pd [*2] |=> !pump.up && !pump.dn) else $error("pump on in power-down");
    a_div8_edge: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(xtal_div8_out) |-> $past(osc_rise) && $past(x8_q) == 2'h3)
        else $error("div8 toggled off count");
endmodule : psd_core

// >>> psd_core_tb.sv
// self-checking bench for the synthesizer divider core
// assumes nothing of apb wait states; the hang guard ends any wait
module psd_core_tb
    import psd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] exp;
        logic err;
    } psd_row_t;

    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, rf_half, osc_half;
    logic [31:0] pwdata, prdata, rd;
    logic er, rf_in, osc_input, hw_powerdown_n, addr_select_in;
    logic vco_switch_a_o, vco_switch_a_oe, vco_switch_b, xtal_div8_out;
    psd_pump_t pump;
    int n_fail, check_count, cyc, u, d, bad, osc_r, x_t, lat;
    // code 15 reference ratio times an 8-cycle oscillator period
    localparam int REF_SLOW = 1920 * 8;
    psd_row_t rows [14];

    psd_core dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rf_in(rf_in), .osc_input(osc_input),
        .hw_powerdown_n(hw_powerdown_n), .addr_select_in(addr_select_in),
        .pump(pump), .vco_switch_a_o(vco_switch_a_o),
        .vco_switch_a_oe(vco_switch_a_oe), .vco_switch_b(vco_switch_b),
        .xtal_div8_out(xtal_div8_out));

    psd_src_model src_u (.clk(clk), .rst_n(rst_n), .rf_half(rf_half),
        .osc_half(osc_half), .rf_in(rf_in), .osc_input(osc_input));

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no wait-state count assumed; only the hang guard ends this
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // pump and divided-clock activity over a fixed span
    task automatic window();
        logic po, px;
        po = osc_input;
        px = xtal_div8_out;
        u = 0;
        d = 0;
        bad = 0;
        osc_r = 0;
        x_t = 0;
        repeat (16000) begin
            @(posedge clk);
            if (pump.up === 1'b1) u++;
            if (pump.dn === 1'b1) d++;
            if (pump.hiz !== ~(pump.up | pump.dn)) bad++;
            if (osc_input && !po) osc_r++;
            if (xtal_div8_out !== px) x_t++;
            po = osc_input;
            px = xtal_div8_out;
        end
    endtask : window

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    initial begin
        // reset values, partial ratio write, status, address, unmapped
        rows = '{
            '{0, OFF_A, 0, 32'h0000000e, 0}, '{0, OFF_B, 0, 32'h000000a5, 0},
            '{0, OFF_C, 0, 32'h00000000, 0}, '{0, OFF_D, 0, 32'h00000000, 0},
            '{1, OFF_C, 32'h55, 0, 0}, '{1, OFF_D, 32'h3c, 0, 0},
            '{1, OFF_D, 32'h3d, 0, 0}, '{0, OFF_C, 0, 32'h00000055, 0},
            '{0, OFF_B, 0, 32'h000000a5, 0}, '{0, OFF_D, 0, 32'h0000003d, 0},
            '{1, OFF_STAT, 32'hff, 0, 0}, '{0, OFF_STAT, 0, 32'h00000010, 0},
            '{0, OFF_SADDR, 0, 32'h000000c6, 0}, '{0, 8'h18, 0, 0, 1}};
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        hw_powerdown_n = 1'b1;
        addr_select_in = 1'b0;
        rf_half = 8'h02;
        osc_half = 8'h02;
        repeat (16) @(posedge clk);
        chk(pump.hiz, 1);
        chk(pump.up | pump.dn, 0);
        chk(vco_switch_a_oe, 1);
        chk(vco_switch_a_o, 0);
        chk(vco_switch_b, 0);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].exp);
            chk(er, rows[i].err);
        end
        // select pin high shows as a zero in bit 1 of the address
        addr_select_in <= 1'b1;
        repeat (2) @(posedge clk);
        apb(0, OFF_SADDR, 0);
        chk(rd, 32'h000000c4);
        // fast reference against slow divider, 1 mA pump
        apb(1, OFF_A, 32'h20);
        repeat (4) @(posedge clk);
        chk(pump.hi_cur, 1);
        window();
        chk(32'(u > d), 1);
        chk(bad, 0);
        chk(vco_switch_a_oe, 1);
        chk(32'(x_t >= osc_r / 4 - 1 && x_t <= osc_r / 4 + 1), 1);
        // inverted detector, buffer switches set
        apb(1, OFF_B, 32'hbc);
        repeat (4) @(posedge clk);
        chk(vco_switch_b, 1);
        window();
        chk(32'(d > u), 1);
        chk(vco_switch_a_oe, 1);
        // slow reference, 0.5 mA pump; the divider is still in its
        // long first period after reset, so the reference still leads
        apb(1, OFF_B, 32'hac);
        apb(1, OFF_A, 32'h0f);
        osc_half <= 8'h04;
        repeat (4) @(posedge clk);
        chk(pump.hi_cur, 0);
        chk(vco_switch_b, 1);
        window();
        chk(32'(u > d), 1);
        chk(bad, 0);
        // hardware power-down idles pump, registers stay reachable
        hw_powerdown_n <= 1'b0;
        repeat (6) @(posedge clk);
        window();
        chk(u + d, 0);
        chk(pump.hiz, 1);
        apb(0, OFF_A, 0);
        chk(rd, 32'h0000000f);
        // leaving power-down restarts the reference count, so the
        // first up comes one full reference period later; slack
        // covers synchroniser and detector delay and osc phase
        hw_powerdown_n <= 1'b1;
        lat = 0;
        while (pump.up !== 1'b1) begin
            @(posedge clk);
            lat++;
        end
        chk(32'(lat >= REF_SLOW - 8 && lat <= REF_SLOW + 16), 1);
        end_sim();
    end
endmodule : psd_core_tb

// >>> psd_pkg.sv
// constants, types and lookups for the synthesizer divider core
// assumes a single 50 MHz system clock and an APB register port
package psd_pkg;
    // clock and lock-detector timing
    localparam int CLK_MHZ = 50;
    localparam int ERR_NS = 200;
    // longest time, so rounded down to whole cycles
    localparam int ERR_CYC_I = (ERR_NS * CLK_MHZ) / 1000;
    localparam logic [3:0] ERR_CYC = 4'(ERR_CYC_I);
    localparam logic [2:0] RELOCK_REFS = 3'h6;

    // register byte offsets on the APB port
    localparam logic [7:0] OFF_A = 8'h00;
    localparam logic [7:0] OFF_B = 8'h04;
    localparam logic [7:0] OFF_C = 8'h08;
    localparam logic [7:0] OFF_D = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_SADDR = 8'h14;

    // reset values
    localparam logic [7:0] RST_A = 8'h0e;
    localparam logic [7:0] RST_B = 8'ha5;
    localparam logic [7:0] RST_C = 8'h00;
    localparam logic [7:0] RST_D = 8'h00;

    // field positions
    localparam int A_PD = 7;
    localparam int A_ICP = 5;
    localparam int A_REF = 0;
    localparam int B_PHI = 4;
    localparam int B_VCO_SWITCH_B = 3;
    localparam int B_VCO_SWITCH_A = 2;
    localparam int STAT_UNLOCK = 4;

    // fixed part of the serial slave address
    localparam logic [5:0] SADDR_FIXED = 6'h31;

    // main divider limits and prescaler top count
    localparam logic [17:0] RATIO_MIN = 18'h00800;
    localparam logic [4:0] PRE_TOP = 5'h1f;

    typedef enum logic [1:0] {
        PSD_LOCKED = 2'b01,
        PSD_UNLOCKED = 2'b10
    } psd_lock_t;

    // charge pump command
    typedef struct packed {
        logic up;
        logic dn;
        logic hiz;
        logic hi_cur;
    } psd_pump_t;

    // reference ratio for a four-bit select code
    function automatic logic [10:0] psd_ref_ratio(input logic [3:0] sel);
        logic [10:0] r;
        r = 11'h080;
        case (sel)
            4'h0: r = 11'h080;
            4'h1: r = 11'h0a0;
            4'h2: r = 11'h0c0;
            4'h3: r = 11'h0f0;
            4'h4: r = 11'h100;
            4'h5: r = 11'h140;
            4'h6: r = 11'h180;
            4'h7: r = 11'h1e0;
            4'h8: r = 11'h200;
            4'h9: r = 11'h280;
            4'ha: r = 11'h300;
            4'hb: r = 11'h3c0;
            4'hc: r = 11'h400;
            4'hd: r = 11'h500;
            4'he: r = 11'h600;
            default: r = 11'h780;
        endcase
        return r;
    endfunction : psd_ref_ratio

    // ratios below the floor are lifted by the floor value
    function automatic logic [17:0] psd_eff_ratio(input logic [17:0] x);
        return (x < RATIO_MIN) ? (x + RATIO_MIN) : x;
    endfunction : psd_eff_ratio
endpackage : psd_pkg

// >>> psd_src_model.sv
// far-side signal sources: prescaler-side rf feed and crystal clock
// assumes periods given in clk cycles, each half at least two cycles
module psd_src_model
    import psd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] rf_half,
    input wire logic [7:0] osc_half,
    output logic rf_in,
    output logic osc_input
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rf_cnt_q;
    logic [7:0] osc_cnt_q;

    // free-running square waves; >= compare survives a period change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rf_cnt_q <= 8'h00;
            osc_cnt_q <= 8'h00;
            rf_in <= 1'b0;
            osc_input <= 1'b0;
        end else begin
            rf_cnt_q <= (rf_cnt_q >= rf_half - 8'h01) ? 8'h00
                                                      : rf_cnt_q + 8'h01;
            osc_cnt_q <= (osc_cnt_q >= osc_half - 8'h01) ? 8'h00
                                                          : osc_cnt_q + 8'h01;
            if (rf_cnt_q >= rf_half - 8'h01) rf_in <= ~rf_in;
            if (osc_cnt_q >= osc_half - 8'h01) osc_input <= ~osc_input;
        end
    end
endmodule : psd_src_model
